/* File: logic/tcrt_cadence.v */
// one oscillator's active/inactive cadence sequencer
`timescale 1ns/1ns
module tcrt_cadence #(
  parameter CW = 16
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // timebase and control
  input wire tick,
  input wire osc_en,
  input wire on_en,
  input wire off_en,
  input wire zc_en,
  input wire zero_cross,
  input wire [CW-1:0] on_count,
  input wire [CW-1:0] off_count,
  // state and events
  output reg active_reg,
  output reg on_done_reg,
  output reg off_done_reg
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ON = 2'h1;
  localparam [1:0] ST_WAIT_ZC = 2'h2;
  localparam [1:0] ST_OFF = 2'h3;
  localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

  reg [1:0] state_reg;
  reg [CW-1:0] cnt_reg;

  // a count of zero is treated as one tick so the cadence never stalls
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= {CW{1'b0}};
      active_reg <= 1'b0;
      on_done_reg <= 1'b0;
      off_done_reg <= 1'b0;
    end
    else
    begin
      on_done_reg <= 1'b0;
      off_done_reg <= 1'b0;
      if (!osc_en)
      begin
        state_reg <= ST_IDLE;
        active_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            state_reg <= ST_ON;
            active_reg <= 1'b1;
            cnt_reg <= on_count;
          end
          ST_ON:
          begin
            if (on_en && tick)
            begin
              if (cnt_reg <= ONE)
              begin
                on_done_reg <= 1'b1;
                if (zc_en)
                  state_reg <= ST_WAIT_ZC;
                else
                begin
                  state_reg <= ST_OFF;
                  active_reg <= 1'b0;
                  cnt_reg <= off_count;
                end
              end
              else
                cnt_reg <= cnt_reg - ONE;
            end
          end
          ST_WAIT_ZC:
          begin
            if (zero_cross)
            begin
              state_reg <= ST_OFF;
              active_reg <= 1'b0;
              cnt_reg <= off_count;
            end
          end
          ST_OFF:
          begin
            if (off_en && tick)
            begin
              if (cnt_reg <= ONE)
              begin
                off_done_reg <= 1'b1;
                state_reg <= ST_ON;
                active_reg <= 1'b1;
                cnt_reg <= on_count;
              end
              else
                cnt_reg <= cnt_reg - ONE;
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
            active_reg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* File: logic/tcrt_defines.vh */
// register offsets, field positions, reset values and timing constants of the cadence timers
`ifndef TCRT_DEFINES_VH
`define TCRT_DEFINES_VH

// register indices; byte address is four times the index
`define TCRT_IDX_TONE1_ON_LO 8'h24
`define TCRT_IDX_TONE1_ON_HI 8'h25
`define TCRT_IDX_TONE1_OFF_LO 8'h26
`define TCRT_IDX_TONE1_OFF_HI 8'h27
`define TCRT_IDX_TONE2_ON_LO 8'h28
`define TCRT_IDX_TONE2_ON_HI 8'h29
`define TCRT_IDX_TONE2_OFF_LO 8'h2A
`define TCRT_IDX_TONE2_OFF_HI 8'h2B
`define TCRT_IDX_METER_ON_LO 8'h2C
`define TCRT_IDX_METER_ON_HI 8'h2D
`define TCRT_IDX_METER_OFF_LO 8'h2E
`define TCRT_IDX_METER_OFF_HI 8'h2F
`define TCRT_IDX_RING_ON_LO 8'h30
`define TCRT_IDX_RING_ON_HI 8'h31
`define TCRT_IDX_RING_OFF_LO 8'h32
`define TCRT_IDX_RING_OFF_HI 8'h33
`define TCRT_IDX_FSK_BUF 8'h34
`define TCRT_IDX_HOOK_DEB 8'h3F
`define TCRT_IDX_OSC_CTRL_BASE 8'h40
`define TCRT_IDX_OSC_CTRL_LAST 8'h43
`define TCRT_IDX_FSK_CTRL 8'h44
`define TCRT_IDX_IRQ_STATUS 8'h45
`define TCRT_IDX_IRQ_MASK 8'h46

// oscillator control fields
`define TCRT_OSC_ACTIVE_BIT 7
`define TCRT_OSC_ZC_BIT 5
`define TCRT_OSC_ON_EN_BIT 4
`define TCRT_OSC_OFF_EN_BIT 3
`define TCRT_OSC_EN_BIT 2

// fsk control fields
`define TCRT_FSK_GEN_EN_BIT 0
`define TCRT_FSK_QUAL_BIT 1

// interrupt status layout
`define TCRT_IRQ_W 10
`define TCRT_IRQ_FSK_BIT 8
`define TCRT_IRQ_HOOK_BIT 9

// reset values
`define TCRT_TIMER_RST 8'h00
`define TCRT_FSK_BUF_RST 1'b0
`define TCRT_HOOK_DEB_RST 8'h54
`define TCRT_OSC_CTRL_RST 4'h0

// timing
`define TCRT_CLK_NS 10
`define TCRT_TICK_NS 125000
`define TCRT_TICK_CYCLES (`TCRT_TICK_NS / `TCRT_CLK_NS)
`define TCRT_DEB_STEP_NS 1250000
`define TCRT_DEB_STEP_TICKS (`TCRT_DEB_STEP_NS / `TCRT_TICK_NS)

`endif

/* File: logic/tcrt_top.v */
// tone, metering and ringing cadence timers with fsk bit buffer and hook debounce, ahb-lite slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "tcrt_defines.vh"

module tcrt_top #(
  parameter integer TICK_CYCLES = `TCRT_TICK_CYCLES,
  parameter integer DEB_STEP_TICKS = `TCRT_DEB_STEP_TICKS,
  parameter CW = 16
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // oscillator datapath, same clock
  input wire [3:0] zero_cross,
  output wire [3:0] osc_active,
  // fsk modulator, same clock
  input wire fsk_bit_req,
  output reg fsk_bit_out,
  // loop closure pin, asynchronous
  input wire loop_closed_pin,
  output reg hook_detected,
  // interrupt
  output reg irq
);

  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam integer DEB_LAST_I = DEB_STEP_TICKS - 1;
  localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
  localparam [7:0] DEB_LAST = DEB_LAST_I[7:0];
  localparam NOSC = 4;
  localparam RING = 3;

  // timebase: 125 us tick and 1.25 ms debounce step
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  reg [7:0] deb_div_reg;
  reg step_reg;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
      deb_div_reg <= 8'h00;
      step_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= 1'b0;
      step_reg <= 1'b0;
      if (tick_cnt_reg >= TICK_LAST)
      begin
        tick_cnt_reg <= 16'h0000;
        tick_reg <= 1'b1;
      end
      else
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      if (tick_reg)
      begin
        if (deb_div_reg >= DEB_LAST)
        begin
          deb_div_reg <= 8'h00;
          step_reg <= 1'b1;
        end
        else
          deb_div_reg <= deb_div_reg + 8'h01;
      end
    end
  end

  // ahb address phase capture
  reg wr_pend_reg;
  reg [7:0] wr_idx_reg;
  wire take = hsel && htrans[1] && hready;
  wire [7:0] rd_idx = haddr[9:2];
  wire [7:0] rd_toff = rd_idx - `TCRT_IDX_TONE1_ON_LO;
  wire rd_is_tim = (rd_idx >= `TCRT_IDX_TONE1_ON_LO) && (rd_idx <= `TCRT_IDX_RING_OFF_HI);
  wire [7:0] wr_toff = wr_idx_reg - `TCRT_IDX_TONE1_ON_LO;
  wire wr_is_tim = (wr_idx_reg >= `TCRT_IDX_TONE1_ON_LO) && (wr_idx_reg <= `TCRT_IDX_RING_OFF_HI);
  wire [7:0] rd_coff = rd_idx - `TCRT_IDX_OSC_CTRL_BASE;
  wire rd_is_ctl = (rd_idx >= `TCRT_IDX_OSC_CTRL_BASE) && (rd_idx <= `TCRT_IDX_OSC_CTRL_LAST);
  wire [7:0] wr_coff = wr_idx_reg - `TCRT_IDX_OSC_CTRL_BASE;
  wire wr_is_ctl = (wr_idx_reg >= `TCRT_IDX_OSC_CTRL_BASE) && (wr_idx_reg <= `TCRT_IDX_OSC_CTRL_LAST);

  // register storage
  reg [7:0] tim_lo_reg [0:7];
  reg [7:0] tim_hi_reg [0:7];
  reg [15:0] tim_cur_reg [0:7];
  reg [3:0] osc_ctrl_reg [0:NOSC-1];
  reg fsk_buf_reg;
  reg fsk_gen_enable;
  reg ring_fsk_qualifier;
  reg [7:0] hook_debounce_value;
  reg [`TCRT_IRQ_W-1:0] irq_status_reg;
  reg [`TCRT_IRQ_W-1:0] irq_mask_reg;
  wire [`TCRT_IRQ_W-1:0] irq_event;
  integer i;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take && hwrite;
      if (take)
        wr_idx_reg <= rd_idx;
    end
  end

  // write path; the hi byte commits both halves so a running count never sees a torn value
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        tim_lo_reg[i] <= `TCRT_TIMER_RST;
        tim_hi_reg[i] <= `TCRT_TIMER_RST;
        tim_cur_reg[i] <= {`TCRT_TIMER_RST, `TCRT_TIMER_RST};
      end
      for (i = 0; i < NOSC; i = i + 1)
        osc_ctrl_reg[i] <= `TCRT_OSC_CTRL_RST;
      fsk_buf_reg <= `TCRT_FSK_BUF_RST;
      fsk_gen_enable <= 1'b0;
      ring_fsk_qualifier <= 1'b0;
      hook_debounce_value <= `TCRT_HOOK_DEB_RST;
      irq_mask_reg <= {`TCRT_IRQ_W{1'b0}};
    end
    else if (wr_pend_reg)
    begin
      if (wr_is_tim)
      begin
        if (wr_toff[0])
        begin
          tim_hi_reg[wr_toff[3:1]] <= hwdata[7:0];
          tim_cur_reg[wr_toff[3:1]] <= {hwdata[7:0], tim_lo_reg[wr_toff[3:1]]};
        end
        else
          tim_lo_reg[wr_toff[3:1]] <= hwdata[7:0];
      end
      if (wr_is_ctl)
        osc_ctrl_reg[wr_coff[1:0]] <= hwdata[`TCRT_OSC_ZC_BIT:`TCRT_OSC_EN_BIT];
      if (wr_idx_reg == `TCRT_IDX_FSK_BUF)
        fsk_buf_reg <= hwdata[0];
      if (wr_idx_reg == `TCRT_IDX_FSK_CTRL)
      begin
        fsk_gen_enable <= hwdata[`TCRT_FSK_GEN_EN_BIT];
        ring_fsk_qualifier <= hwdata[`TCRT_FSK_QUAL_BIT];
      end
      if (wr_idx_reg == `TCRT_IDX_HOOK_DEB)
        hook_debounce_value <= hwdata[7:0];
      if (wr_idx_reg == `TCRT_IDX_IRQ_MASK)
        irq_mask_reg <= hwdata[`TCRT_IRQ_W-1:0];
    end
  end

  // interrupt status: write one to clear, a same-cycle event wins
  wire [`TCRT_IRQ_W-1:0] irq_clr = (wr_pend_reg && (wr_idx_reg == `TCRT_IDX_IRQ_STATUS)) ?
                                   hwdata[`TCRT_IRQ_W-1:0] : {`TCRT_IRQ_W{1'b0}};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status_reg <= {`TCRT_IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_event;
      irq <= |(((irq_status_reg & ~irq_clr) | irq_event) & irq_mask_reg);
    end
  end

  // cadence sequencers: tone 1, tone 2, meter, ring
  wire [3:0] on_done;
  wire [3:0] off_done;
  genvar g;
  generate
    for (g = 0; g < NOSC; g = g + 1)
    begin : g_osc
      tcrt_cadence #(
        .CW(CW)
      ) u_cad (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_reg),
        .osc_en(osc_ctrl_reg[g][0]),
        .on_en(osc_ctrl_reg[g][2]),
        .off_en(osc_ctrl_reg[g][1]),
        .zc_en(osc_ctrl_reg[g][3]),
        .zero_cross(zero_cross[g]),
        .on_count(tim_cur_reg[2*g][CW-1:0]),
        .off_count(tim_cur_reg[2*g+1][CW-1:0]),
        .active_reg(osc_active[g]),
        .on_done_reg(on_done[g]),
        .off_done_reg(off_done[g])
      );
    end
  endgenerate

  // fsk: the modulator's request takes the buffered bit only when generation is qualified
  reg fsk_taken_reg;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fsk_bit_out <= 1'b0;
      fsk_taken_reg <= 1'b0;
    end
    else
    begin
      fsk_taken_reg <= 1'b0;
      if (fsk_bit_req && fsk_gen_enable && ring_fsk_qualifier)
      begin
        fsk_bit_out <= fsk_buf_reg;
        fsk_taken_reg <= 1'b1;
      end
    end
  end

  // loop closure: two-flop synchroniser, then debounce during the ring silent period
  reg hook_meta_reg;
  reg hook_sync_reg;
  reg [7:0] deb_cnt_reg;
  reg hook_evt_reg;
  wire silent = osc_ctrl_reg[RING][0] && !osc_active[RING];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hook_meta_reg <= 1'b0;
      hook_sync_reg <= 1'b0;
    end
    else
    begin
      hook_meta_reg <= loop_closed_pin;
      hook_sync_reg <= hook_meta_reg;
    end
  end

  // detection only arms in the silent gap; ring trip during the burst is another block's job
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      deb_cnt_reg <= 8'h00;
      hook_detected <= 1'b0;
      hook_evt_reg <= 1'b0;
    end
    else
    begin
      hook_evt_reg <= 1'b0;
      if (!hook_sync_reg)
      begin
        deb_cnt_reg <= 8'h00;
        hook_detected <= 1'b0;
      end
      else if (!silent)
        deb_cnt_reg <= 8'h00;
      else if (!hook_detected)
      begin
        if (deb_cnt_reg >= hook_debounce_value)
        begin
          hook_detected <= 1'b1;
          hook_evt_reg <= 1'b1;
        end
        else if (step_reg)
          deb_cnt_reg <= deb_cnt_reg + 8'h01;
      end
    end
  end

  assign irq_event = {hook_evt_reg, fsk_taken_reg, off_done, on_done};

  // read path: data registered at the address phase, zero wait states
  reg [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    if (rd_is_tim)
      rd_byte = rd_toff[0] ? tim_hi_reg[rd_toff[3:1]] : tim_lo_reg[rd_toff[3:1]];
    else if (rd_is_ctl)
      rd_byte = {osc_active[rd_coff[1:0]], 1'b0, osc_ctrl_reg[rd_coff[1:0]], 2'b00};
    else if (rd_idx == `TCRT_IDX_FSK_BUF)
      rd_byte = {7'h00, fsk_buf_reg};
    else if (rd_idx == `TCRT_IDX_HOOK_DEB)
      rd_byte = hook_debounce_value;
    else if (rd_idx == `TCRT_IDX_FSK_CTRL)
      rd_byte = {6'h00, ring_fsk_qualifier, fsk_gen_enable};
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite)
      begin
        if (rd_idx == `TCRT_IDX_IRQ_STATUS)
          hrdata <= {22'h000000, irq_status_reg};
        else if (rd_idx == `TCRT_IDX_IRQ_MASK)
          hrdata <= {22'h000000, irq_mask_reg};
        else
          hrdata <= {24'h000000, rd_byte};
      end
    end
  end

endmodule

/* File: sim/tcrt_top_monitor.sv */
// bus, fsk, status and hook relations of the cadence timer block
`timescale 1ns/1ns
module tcrt_top_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // outputs and pins
  input wire logic [3:0] osc_active,
  input wire logic fsk_bit_req,
  input wire logic fsk_bit_out,
  input wire logic loop_closed_pin,
  input wire logic hook_detected,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_take = hsel && htrans[1] && !hwrite && hready;
  hready_one_a: assert property (hreadyout) else $error("wait state inserted");
  okay_resp_a: assert property (!hresp) else $error("error response");
  rd_upper_a: assert property ($past(rd_take) |-> hrdata[31:10] == 22'h0) else $error("read upper bits set");
  fsk_pad_a: assert property ($past(rd_take && haddr[9:2] == 8'h34) |-> hrdata[7:1] == 7'h00)
    else $error("fsk buffer pad bits set");
  ring_status_a: assert property ($past(rd_take && haddr[9:2] == 8'h43) |-> hrdata[7] == $past(osc_active[3]))
    else $error("ring status bit differs from output");
  rd_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata)) else $error("read data moved");
  fsk_hold_a: assert property (!$past(fsk_bit_req) |-> $stable(fsk_bit_out))
    else $error("fsk bit changed without request");
  hook_rise_a: assert property ($rose(hook_detected) |-> $past(loop_closed_pin, 2))
    else $error("hook seen without closure");
  hook_clear_a: assert property ((!loop_closed_pin)[*5] |-> !hook_detected)
    else $error("hook held with pin low");
  cover property ($rose(fsk_bit_out));
  cover property ($rose(osc_active[3]));
  cover property ($rose(hook_detected));
  cover property ($rose(irq));
endmodule

bind tcrt_top tcrt_top_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .osc_active(osc_active), .fsk_bit_req(fsk_bit_req), .fsk_bit_out(fsk_bit_out),
  .loop_closed_pin(loop_closed_pin), .hook_detected(hook_detected), .irq(irq));

/* File: sim/tone_ring_cadence_timers_tb.sv */
// self-checking bench for the cadence timer block
`timescale 1ns/1ns
module tone_ring_cadence_timers_tb;
  // short tick keeps cadences a few cycles long
  localparam integer T = 4;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'b010;
  reg [31:0] hwdata = 32'h0;
  reg [3:0] zero_cross = 4'h0;
  reg fsk_bit_req = 1'b0;
  reg loop_closed_pin = 1'b0;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [3:0] osc_active;
  wire fsk_bit_out;
  wire hook_detected;
  wire irq;
  integer miscompares = 0;
  integer checked = 0;
  integer k;
  reg [31:0] rdv;
  always #5 hclk = ~hclk;
  tcrt_top #(.TICK_CYCLES(T), .DEB_STEP_TICKS(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .zero_cross(zero_cross), .osc_active(osc_active),
    .fsk_bit_req(fsk_bit_req), .fsk_bit_out(fsk_bit_out), .loop_closed_pin(loop_closed_pin),
    .hook_detected(hook_detected), .irq(irq));
  task results;
  begin
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    checked = checked + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  end
  endtask
  task hang(input integer n);
  begin
    if (n > 400)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t wait ran out", $time);
      results;
    end
  end
  endtask
  // hready is sampled at every edge, never assumed
  task rdy;
    integer n;
  begin
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n = n + 1;
      hang(n);
      @(posedge hclk);
    end
  end
  endtask
  task bus(input w, input [7:0] idx, input [31:0] wd);
  begin
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    rdy;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy;
    rdv = hrdata;
  end
  endtask
  task wr(input [7:0] idx, input [31:0] d);
  begin
    bus(1'b1, idx, d);
  end
  endtask
  task rd(input [7:0] idx, input [31:0] e);
  begin
    bus(1'b0, idx, 32'h0);
    chk(rdv, e);
  end
  endtask
  task wosc(input [1:0] i, input v);
    integer n;
  begin
    n = 0;
    while (osc_active[i] !== v)
    begin
      @(posedge hclk);
      n = n + 1;
      hang(n);
    end
  end
  endtask
  task meas(input [1:0] i, input v, output integer n);
  begin
    n = 0;
    while (osc_active[i] === v && n < 400)
    begin
      n = n + 1;
      @(posedge hclk);
    end
  end
  endtask
  // second and later periods are whole ticks, the first one is not
  task cad(input [1:0] i, input [7:0] on, input [7:0] off);
    integer n;
    reg [7:0] b;
  begin
    b = 8'h24 + {4'h0, i, 2'b00};
    wr(b, on);
    wr(b + 8'h01, 32'h0);
    wr(b + 8'h02, off);
    wr(b + 8'h03, 32'h0);
    wr(8'h40 + i, 32'h1C);
    wosc(i, 1'b1);
    wosc(i, 1'b0);
    meas(i, 1'b0, n);
    chk(n, off * T);
    meas(i, 1'b1, n);
    chk(n, on * T);
    wr(8'h40 + i, 32'h0);
    $display("cadence %0d done", i);
  end
  endtask
  // tone 2 keeps its on=2 off=1 counts from the cadence test
  task t_zc;
  begin
    wr(8'h45, 32'h3FF);
    wr(8'h41, 32'h3C);
    wosc(2'd1, 1'b1);
    repeat (3 * T) @(posedge hclk);
    chk(osc_active[1], 1'b1);
    rd(8'h45, 32'h002);
    zero_cross[1] <= 1'b1;
    @(posedge hclk);
    zero_cross[1] <= 1'b0;
    @(posedge hclk);
    chk(osc_active[1], 1'b0);
    wosc(2'd1, 1'b1);
    wr(8'h41, 32'h0);
    $display("zero cross test done");
  end
  endtask
  task pulse;
  begin
    fsk_bit_req <= 1'b1;
    @(posedge hclk);
    fsk_bit_req <= 1'b0;
    @(posedge hclk);
  end
  endtask
  task t_regs;
  begin
    for (k = 8'h24; k <= 8'h34; k = k + 1)
      rd(k[7:0], 32'h0);
    rd(8'h3F, 32'h54);
    for (k = 8'h24; k <= 8'h33; k = k + 1)
    begin
      wr(k[7:0], k[7:0] ^ 8'hA5);
      rd(k[7:0], k[7:0] ^ 8'hA5);
    end
    wr(8'h35, 32'hFF);
    rd(8'h35, 32'h0);
    $display("register test done");
  end
  endtask
  task t_fsk;
  begin
    wr(8'h45, 32'h3FF);
    wr(8'h34, 32'hFF);
    rd(8'h34, 32'h01);
    pulse;
    chk(fsk_bit_out, 1'b0);
    wr(8'h44, 32'h03);
    pulse;
    chk(fsk_bit_out, 1'b1);
    chk(irq, 1'b0);
    rd(8'h45, 32'h100);
    wr(8'h46, 32'h100);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
    wr(8'h45, 32'h100);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    $display("fsk test done");
  end
  endtask
  task t_hook;
    integer n;
  begin
    wr(8'h3F, 32'h02);
    wr(8'h30, 32'h01);
    wr(8'h31, 32'h0);
    wr(8'h45, 32'h3FF);
    wr(8'h43, 32'h14);
    wosc(2'd3, 1'b1);
    wosc(2'd3, 1'b0);
    repeat (20) @(posedge hclk);
    chk(osc_active[3], 1'b0);
    loop_closed_pin <= 1'b1;
    n = 0;
    while (hook_detected !== 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n = n + 1;
    end
    chk(n >= 12 && n <= 40, 1'b1);
    rd(8'h45, 32'h208);
    loop_closed_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(hook_detected, 1'b0);
    wr(8'h43, 32'h0);
    $display("hook test done");
  end
  endtask
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    cad(2'd0, 8'h03, 8'h02);
    cad(2'd1, 8'h02, 8'h01);
    cad(2'd2, 8'h01, 8'h02);
    cad(2'd3, 8'h02, 8'h01);
    t_zc;
    t_fsk;
    t_hook;
    results;
  end
endmodule
